// file: bbx_exec.sv
`timescale 1ns/10ps
// Function
// - Relative jump decoded from prefix 1101, zero bit, 11-bit signed offset
// - Jump target is current counter plus twice offset, -1024..1023
// - Jump takes two cycles; counter written in Q4, second cycle idle
// - Set-bit prefix 1000 forces chosen bit of addressed register high
// - Bank bit zero selects access bank, one uses bank select register
// - Extended set, bank bit zero, address <= 95 uses indexed offset
// - Skip-if-clear prefix 1011 skips next instruction when bit is zero
// - Taken skip discards prefetched word and runs a no-op instead
module bbx_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fetch side
    input wire logic [15:0] fetch_word,
    output logic [20:0] pc,
    output logic fetch_en,
    // Register file
    output bbx_pkg::bbx_rf_req_t rf_req,
    input wire logic [7:0] rf_rdata,
    // Context
    input wire logic [3:0] bank_select_reg,
    input wire logic ext_set_en,
    input wire logic [11:0] index_base,
    // Status
    output bbx_pkg::bbx_quarter_t quarter,
    output logic [15:0] exec_word,
    output logic flush,
    output logic flags_we
);
    bbx_pkg::bbx_quarter_t next_quarter;
    logic [15:0] ir;
    logic [7:0] data;
    logic [11:0] data_addr;

    wire [3:0] opc = ir[bbx_pkg::OPC_MSB:bbx_pkg::OPC_LSB];
    wire is_jump = (opc == bbx_pkg::OP_JUMP)
        && !ir[bbx_pkg::JMP_ZERO_POS];
    wire is_set = opc == bbx_pkg::OP_SET;
    wire is_sclr = opc == bbx_pkg::OP_SKIP_CLR;
    wire is_sset = opc == bbx_pkg::OP_SKIP_SET;
    wire is_file = is_set || is_sclr || is_sset;
    wire [2:0] bit_idx = ir[bbx_pkg::BIT_MSB:bbx_pkg::BIT_LSB];
    wire [7:0] bit_mask = 8'h01 << bit_idx;
    wire bit_val = |(data & bit_mask);
    wire skip = (is_sclr && !bit_val) || (is_sset && bit_val);
    // Offset sign-extended and doubled: reach -1024..1023 words
    wire [10:0] ofs = ir[bbx_pkg::OFS_MSB:0];
    wire [20:0] ofs2 = {{9{ofs[10]}}, ofs, 1'b0};
    wire [20:0] target = pc + ofs2;
    wire [20:0] pc_inc = pc + 21'h000002;

    bbx_addr_gen u_addr (
        .file_addr(ir[bbx_pkg::ADR_MSB:0]),
        .bank_sel(ir[bbx_pkg::BANK_POS]),
        .bank_select_reg(bank_select_reg),
        .ext_set_en(ext_set_en),
        .index_base(index_base),
        .data_addr(data_addr)
    );

    always_comb begin
        case (quarter)
            bbx_pkg::Q1: next_quarter = bbx_pkg::Q2;
            bbx_pkg::Q2: next_quarter = bbx_pkg::Q3;
            bbx_pkg::Q3: next_quarter = bbx_pkg::Q4;
            default: next_quarter = bbx_pkg::Q1;
        endcase
    end

    // Register file strobes: read Q2, write Q4
    assign rf_req.addr = data_addr;
    assign rf_req.rd_en = is_file && (quarter == bbx_pkg::Q2);
    assign rf_req.wr_en = is_set && (quarter == bbx_pkg::Q4);
    assign rf_req.wdata = data;
    assign flags_we = 1'b0;
    assign fetch_en = quarter == bbx_pkg::Q4;
    assign flush = fetch_en && ((is_jump) || skip);

    always_ff @(posedge clock) begin
        if (rst) begin
            quarter <= bbx_pkg::Q1;
        end else begin
            quarter <= next_quarter;
        end
    end

    // Q2 read, Q3 modify
    always_ff @(posedge clock) begin
        if (rst) begin
            data <= 8'h00;
        end else if (quarter == bbx_pkg::Q2) begin
            data <= rf_rdata;
        end else if (quarter == bbx_pkg::Q3 && is_set) begin
            data <= data | bit_mask;
        end
    end

    // Counter: jump target in Q4, else normal increment
    always_ff @(posedge clock) begin
        if (rst) begin
            pc <= bbx_pkg::PC_RESET;
        end else if (quarter == bbx_pkg::Q4) begin
            pc <= is_jump ? target : pc_inc;
        end
    end

    // Prefetched word becomes next instruction unless killed
    always_ff @(posedge clock) begin
        if (rst) begin
            ir <= bbx_pkg::NOP_WORD;
        end else if (quarter == bbx_pkg::Q4) begin
            ir <= flush ? bbx_pkg::NOP_WORD : fetch_word;
        end
    end

    assign exec_word = ir;
endmodule : bbx_exec

// file: bbx_pkg.sv
package bbx_pkg;
    // Opcode prefixes (instruction bits 15:12)
    localparam logic [3:0] OP_JUMP = 4'hd;
    localparam logic [3:0] OP_SET = 4'h8;
    localparam logic [3:0] OP_SKIP_CLR = 4'hb;
    localparam logic [3:0] OP_SKIP_SET = 4'ha;
    // Field positions
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 12;
    localparam int JMP_ZERO_POS = 11;
    localparam int OFS_MSB = 10;
    localparam int BIT_MSB = 11;
    localparam int BIT_LSB = 9;
    localparam int BANK_POS = 8;
    localparam int ADR_MSB = 7;
    // Indexed literal offset limit
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    // Access bank upper half starts here
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    // Reset values
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bbx_quarter_t;

    // Register file access carried as one bundle
    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [11:0] addr;
        logic [7:0] wdata;
    } bbx_rf_req_t;
endpackage : bbx_pkg

// file: bbx_addr_gen.sv
`timescale 1ns/10ps
// Forms the 12-bit data address of a file operand
module bbx_addr_gen (
    // Operand
    input wire logic [7:0] file_addr,
    input wire logic bank_sel,
    // Context
    input wire logic [3:0] bank_select_reg,
    input wire logic ext_set_en,
    input wire logic [11:0] index_base,
    // Result
    output logic [11:0] data_addr
);
    wire use_idx;
    wire [11:0] acc_addr;
    wire [11:0] idx_addr;
    wire [11:0] bsr_addr;

    assign use_idx = ext_set_en && !bank_sel
        && (file_addr <= bbx_pkg::IDX_LIMIT);
    assign idx_addr = index_base + {4'h0, file_addr};
    assign acc_addr = (file_addr < bbx_pkg::ACC_SPLIT) ?
        {4'h0, file_addr} : {bbx_pkg::ACC_HI_BANK, file_addr};
    assign bsr_addr = {bank_select_reg, file_addr};
    assign data_addr = use_idx ? idx_addr :
        (bank_sel ? bsr_addr : acc_addr);
endmodule : bbx_addr_gen

// file: bbx_rf_model.sv
`timescale 1ns/10ps
module bbx_rf_model (
    // Register file side
    input bbx_pkg::bbx_rf_req_t rf_req,
    output logic [7:0] rf_rdata
);
    // Byte is low address mixed with bank, so the bank shows in the data
    assign rf_rdata = rf_req.rd_en ?
        (rf_req.addr[7:0] ^ {rf_req.addr[11:8], 4'h0}) : ~rf_req.addr[7:0];
endmodule : bbx_rf_model

// file: bbx_checker.sv
`timescale 1ns/10ps
module bbx_checker (
    // Watched ports
    input logic clock, rst, fetch_en, flush, input logic [20:0] pc,
    input logic [15:0] exec_word, input logic [7:0] rf_rdata,
    input logic [3:0] bank_select_reg, input bbx_pkg::bbx_rf_req_t rf_req,
    input logic ext_set_en,
    input logic [11:0] index_base
);
    wire [3:0] op = exec_word[15:12];
    wire jmp = fetch_en && exec_word[15:11] == 5'h1a;
    wire [20:0] ofs = {{9{exec_word[10]}}, exec_word[10:0], 1'b0};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_jump_pc: assert property (jmp |=>
        pc == $past(pc) + $past(ofs)) else $error("jump target");
    a_pc_hold: assert property (!fetch_en |=> $stable(pc))
        else $error("pc moved");
    a_jump_flush: assert property (jmp |-> flush)
        else $error("jump not flushed");
    a_flush_nop: assert property (flush |=> exec_word == 16'h0000)
        else $error("no nop");
    a_skip_clr: assert property (fetch_en && op == 4'hb |->
        flush == !$past(rf_rdata[exec_word[11:9]], 2)) else $error("skip");
    a_skip_set: assert property (fetch_en && op == 4'ha |->
        flush == $past(rf_rdata[exec_word[11:9]], 2)) else $error("skip");
    a_set_write: assert property (rf_req.rd_en && op == 4'h8 |->
        ##2 rf_req.wr_en && rf_req.wdata ==
        ($past(rf_rdata, 2) | 8'h01 << exec_word[11:9])) else $error("set");
    a_bank_addr: assert property (rf_req.rd_en && exec_word[8] |->
        rf_req.addr == {bank_select_reg, exec_word[7:0]}) else $error("bank");
    a_idx_addr: assert property (rf_req.rd_en && ext_set_en
        && !exec_word[8] && exec_word[7:0] <= 8'h5f |->
        rf_req.addr == index_base + {4'h0, exec_word[7:0]})
        else $error("indexed address");
    cover property (jmp);
    cover property (flush && !jmp);
    cover property (rf_req.wr_en);
endmodule : bbx_checker
bind bbx_exec bbx_checker i_chk (.*);

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    logic [27:0] rows [11] = '{28'h8e0a_0_8a, 28'hb00b_0_00, 28'hb40b_1_00,
        28'ha00b_1_00, 28'ha40b_0_00, 28'hd3ff_1_00, 28'hd400_1_00,
        28'hd800_0_00, 28'h800a_0_0b, 28'h8f0a_0_ba, 28'h8e90_0_e0};
    logic ext_set_en = 0;
    logic [11:0] index_base = 12'h000;
    logic [15:0] exec_word;
    bbx_pkg::bbx_quarter_t quarter;
    logic clock = 0, rst = 1, fetch_en, flush, flags_we;
    logic [15:0] fetch_word = 16'h0000;
    logic [20:0] pc, e;
    logic [7:0] rf_rdata;
    bbx_pkg::bbx_rf_req_t rf_req;
    int miscompares = 0, n_compared = 0;
    always #20 clock = ~clock;
    bbx_exec i_dut (.clock, .rst, .fetch_word, .pc, .fetch_en, .rf_req,
        .rf_rdata, .bank_select_reg(4'h3), .ext_set_en, .index_base,
        .quarter, .exec_word, .flush, .flags_we);
    bbx_rf_model i_rf (.rf_req, .rf_rdata);
    task chk(string n, logic [20:0] x, logic [20:0] s);
        n_compared++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task run(logic [27:0] r);
        @(negedge clock iff fetch_en);
        fetch_word = r[27:12];
        @(negedge clock iff fetch_en);
        fetch_word = 16'hffff;
        e = pc + (r[27:23] == 5'h1a ? {{9{r[22]}}, r[22:12], 1'b0} : 21'h2);
        chk("word", 21'(r[27:12]), 21'(exec_word));
        chk("flush", 21'(r[8]), {flags_we, flush});
        chk("write", {r[27:24] == 4'h8, r[7:0]},
            {rf_req.wr_en, rf_req.wdata & {8{rf_req.wr_en}}});
        @(posedge clock);
        #1 chk("pc", e, pc);
        chk("next", r[8] ? 21'h0 : 21'h00ffff, 21'(exec_word));
    endtask : run
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(negedge clock);
        rst = 0;
        foreach (rows[i]) run(rows[i]);
        // Reset in the middle of a set-bit instruction
        @(negedge clock iff fetch_en);
        fetch_word = 16'h8e0a;
        repeat (3) @(negedge clock);
        rst = 1;
        repeat (2) @(negedge clock);
        chk("rst pc", 21'h0, pc);
        chk("rst state", 21'h0, 21'({quarter, exec_word, rf_req.wr_en}));
        rst = 0;
        run(rows[0]);
        // Indexed offset below, at and above the limit
        @(negedge clock);
        ext_set_en = 1;
        index_base = 12'h200;
        run(28'h8e0a_0_aa);
        run(28'h8e5f_0_ff);
        run(28'h8e60_0_e0);
        wrap_up();
    end
    initial begin
        #20000 miscompares++;
        wrap_up();
    end
endmodule : testbench
